//--- hdl/ssee_pkg.sv
// Constants, types and carriers shared by the serial EEPROM slave.
// Assumes a 50 MHz system clock; the serial clock comes from the bus master.
package ssee_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Operation codes, taken as the first byte of each frame.
    localparam logic [7:0] OPC_READ = 8'ha7;
    localparam logic [7:0] OPC_PROG_EN = 8'ha6;
    localparam logic [7:0] OPC_PROG_DIS = 8'ha4;
    localparam logic [7:0] OPC_WRITE = 8'ha2;

    ////////////////////////////////////////////////////////////////////////////
    // Array and page geometry, reset values and filler.
    localparam int ADDR_W = 8;
    localparam int MEM_BYTES = 256;
    localparam int PAGE_BYTES = 4;
    localparam int PAGE_SEL_W = 2;
    localparam int PAGE_TAG_W = 6;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] IDLE_OUT = 8'hff;
    localparam logic [2:0] LAST_BIT = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Programming times and their cycle counts at the system clock rate.
    localparam int CLK_HZ = 50_000_000;
    localparam int PROG_ONE_MS = 10;
    localparam int PROG_PAGE_MS = 20;
    localparam int PROG_ONE_CYC = PROG_ONE_MS * (CLK_HZ / 1000);
    localparam int PROG_PAGE_CYC = PROG_PAGE_MS * (CLK_HZ / 1000);
    localparam int PROG_CNT_W = 21;

    ////////////////////////////////////////////////////////////////////////////
    // Frame phases of the transaction decoder.
    typedef enum logic [2:0]
    {
        PH_OPC = 3'h0,
        PH_RADDR = 3'h1,
        PH_WADDR = 3'h2,
        PH_RDATA = 3'h3,
        PH_WDATA = 3'h4,
        PH_DONE = 3'h5,
        PH_DEAD = 3'h6
    } ssee_phase_e;

    // Received byte with its completion toggle, carried across domains.
    typedef struct packed
    {
        logic tgl;
        logic [7:0] data;
    } ssee_rx_s;

    // State of the serial-clock receiver.
    typedef struct packed
    {
        logic [6:0] sh;
        logic [2:0] cnt;
        ssee_rx_s rx;
    } ssee_link_s;

endpackage

//--- hdl/ssee_spi_eeprom.sv
// Serial peripheral slave of a 256-byte EEPROM: receiver and device core.
// Assumes a bus master that drives the serial clock, select and input line.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Receiver on the serial clock; reset whenever the frame is not active.
module ssee_link_rx
(
    input wire logic sck,
    input wire logic frame_rst,
    input wire logic si,
    output ssee_pkg::ssee_rx_s rx
);
    ssee_pkg::ssee_link_s st;
    ssee_pkg::ssee_link_s next_st;

    // Shifts one bit per rising edge and publishes each full byte.
    always_comb
    begin
        next_st = st;
        next_st.sh = {st.sh[5:0], si};
        next_st.cnt = st.cnt + 3'h1;
        if (st.cnt == ssee_pkg::LAST_BIT)
        begin
            next_st.rx.data = {st.sh, si};
            next_st.rx.tgl = ~st.rx.tgl;
        end
    end

    // The frame's own select ends its state, so no edge is needed after it.
    always_ff @(posedge sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rx = st.rx;
endmodule

////////////////////////////////////////////////////////////////////////////////
// Device core on the system clock with the receiver beside it.
module ssee_spi_eeprom
#(
    parameter int PROG_ONE_CYC = ssee_pkg::PROG_ONE_CYC,
    parameter int PROG_PAGE_CYC = ssee_pkg::PROG_PAGE_CYC
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic DEVICE_SELECT_N,
    input wire logic SERIAL_IN_LINE,
    input wire logic MODE_SPI,
    output logic SERIAL_OUT_LINE,
    output logic SERIAL_OUT_OE,
    output logic VPP_GEN_ON,
    output logic VPP_ARRAY_GATE,
    output logic PROGRAMMING,
    output logic STANDBY
);
    // Last count of a one-byte run and of a page run.
    localparam logic [ssee_pkg::PROG_CNT_W-1:0] ONE_LAST =
        ssee_pkg::PROG_CNT_W'(PROG_ONE_CYC - 1);
    localparam logic [ssee_pkg::PROG_CNT_W-1:0] PAGE_LAST =
        ssee_pkg::PROG_CNT_W'(PROG_PAGE_CYC - 1);

    typedef struct packed
    {
        logic act_m;
        logic act_s;
        logic act_d;
        logic sck_m;
        logic sck_s;
        logic sck_d;
        logic tg_m;
        logic tg_s;
        logic tg_d;
        ssee_pkg::ssee_phase_e phase;
        logic rose;
        logic [2:0] ocnt;
        logic [1:0] obyte;
        logic [7:0] osh;
        logic so;
        logic so_oe;
        logic [7:0] addr;
        logic vpp;
        logic [3:0] mask;
        logic [5:0] page;
        logic [3:0][7:0] lat;
        logic prog;
        logic [ssee_pkg::PROG_CNT_W-1:0] pcnt;
        logic standby;
        logic [ssee_pkg::MEM_BYTES-1:0][7:0] mem;
    } ssee_core_s;

    ssee_core_s st;
    ssee_core_s next_st;
    ssee_pkg::ssee_rx_s rx;
    logic frame_rst;
    logic act_pin;

    ////////////////////////////////////////////////////////////////////////////
    // The frame exists only while selected in four-wire mode.
    assign act_pin = ~DEVICE_SELECT_N & MODE_SPI;
    assign frame_rst = RST | ~act_pin;

    ssee_link_rx u_rx
    (
        .sck(SERIAL_CLOCK_IN),
        .frame_rst(frame_rst),
        .si(SERIAL_IN_LINE),
        .rx(rx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: synchronisers, decoder, output shifter, programming.
    always_comb
    begin
        logic act_rise;
        logic act_fall;
        logic sck_rise;
        logic sck_fall;
        logic rx_evt;
        logic [7:0] load;
        logic [ssee_pkg::PROG_CNT_W-1:0] last;
        next_st = st;
        act_rise = st.act_s & ~st.act_d;
        act_fall = ~st.act_s & st.act_d;
        sck_rise = st.sck_s & ~st.sck_d;
        sck_fall = ~st.sck_s & st.sck_d;
        rx_evt = st.act_s & (st.tg_s != st.tg_d);
        load = ssee_pkg::IDLE_OUT;
        // A run with more than one latched byte takes the page time.
        last = ((st.mask & (st.mask - 4'h1)) != 4'h0) ? PAGE_LAST : ONE_LAST;

        // Two-stage synchronisers; only the second stage is looked at.
        next_st.act_m = act_pin;
        next_st.act_s = st.act_m;
        next_st.act_d = st.act_s;
        next_st.sck_m = SERIAL_CLOCK_IN;
        next_st.sck_s = st.sck_m;
        next_st.sck_d = st.sck_s;
        next_st.tg_m = rx.tgl;
        next_st.tg_s = st.tg_m;
        next_st.tg_d = st.tg_s;

        // Between frames the current address waits in the output shifter.
        if (!st.act_s)
        begin
            next_st.so_oe = 1'b0;
            next_st.phase = ssee_pkg::PH_OPC;
            next_st.rose = 1'b0;
            next_st.ocnt = 3'h0;
            next_st.obyte = 2'h0;
            next_st.osh = st.addr;
            next_st.so = st.addr[7];
        end

        // A new frame drives the address out and stops programming, clearing its count.
        if (act_rise)
        begin
            next_st.so_oe = 1'b1;
            next_st.prog = 1'b0;
            next_st.pcnt = '0;
        end

        // Leaving a frame starts programming when enable and data are both held.
        if (act_fall && st.vpp && (st.mask != 4'h0))
        begin
            next_st.prog = 1'b1;
            next_st.pcnt = '0;
        end

        // A fall counts only after a rise, so an idle-high clock is harmless.
        if (st.act_s && sck_rise)
        begin
            next_st.rose = 1'b1;
        end

        // Output bits change on falling edges, most significant bit first.
        if (st.act_s && sck_fall && st.rose && st.so_oe)
        begin
            next_st.rose = 1'b0;
            next_st.ocnt = st.ocnt + 3'h1;
            if (st.ocnt == ssee_pkg::LAST_BIT)
            begin
                if (st.phase == ssee_pkg::PH_RDATA)
                begin
                    load = st.mem[st.addr];
                end
                else if ((st.phase == ssee_pkg::PH_WDATA) && (st.obyte == 2'h1))
                begin
                    load = st.addr;
                end
                if (st.obyte != 2'h3)
                begin
                    next_st.obyte = st.obyte + 2'h1;
                end
                next_st.osh = load;
                next_st.so = load[7];
            end
            else
            begin
                next_st.osh = {st.osh[6:0], 1'b0};
                next_st.so = st.osh[6];
            end
        end

        // Each completed byte steers the decoder by frame phase.
        if (rx_evt)
        begin
            case (st.phase)
                ssee_pkg::PH_OPC:
                begin
                    // Decoded only on the full first byte.
                    case (rx.data)
                        ssee_pkg::OPC_READ:
                        begin
                            next_st.phase = ssee_pkg::PH_RADDR;
                            next_st.mask = 4'h0;
                        end
                        ssee_pkg::OPC_WRITE:
                        begin
                            next_st.phase = ssee_pkg::PH_WADDR;
                            next_st.mask = 4'h0;
                        end
                        ssee_pkg::OPC_PROG_EN:
                        begin
                            next_st.phase = ssee_pkg::PH_DONE;
                            next_st.vpp = 1'b1;
                            if (st.vpp)
                            begin
                                next_st.mask = 4'h0;
                            end
                        end
                        ssee_pkg::OPC_PROG_DIS:
                        begin
                            next_st.phase = ssee_pkg::PH_DONE;
                            next_st.vpp = 1'b0;
                            next_st.prog = 1'b0;
                        end
                        default:
                        begin
                            next_st.phase = ssee_pkg::PH_DEAD;
                            next_st.so_oe = 1'b0;
                            next_st.mask = 4'h0;
                        end
                    endcase
                end
                ssee_pkg::PH_RADDR:
                begin
                    next_st.addr = rx.data;
                    next_st.phase = ssee_pkg::PH_RDATA;
                end
                ssee_pkg::PH_WADDR:
                begin
                    next_st.addr = rx.data;
                    next_st.page = rx.data[7:2];
                    next_st.phase = ssee_pkg::PH_WDATA;
                end
                ssee_pkg::PH_RDATA:
                begin
                    // Input content is ignored; only the byte boundary counts.
                    next_st.addr = st.addr + 8'h01;
                end
                ssee_pkg::PH_WDATA:
                begin
                    // Bytes outside the first page are dropped from the latch.
                    if (st.addr[7:2] == st.page)
                    begin
                        next_st.lat[st.addr[1:0]] = rx.data;
                        next_st.mask[st.addr[1:0]] = 1'b1;
                    end
                    next_st.addr = st.addr + 8'h01;
                end
                default:
                begin
                    next_st.phase = st.phase;
                end
            endcase
        end

        // Programming runs for its hold time, then commits the latched page.
        if (st.prog && !act_rise)
        begin
            next_st.pcnt = st.pcnt + 1'b1;
            if (!st.vpp)
            begin
                next_st.prog = 1'b0;
            end
            else if (st.pcnt >= last)
            begin
                for (int i = 0; i < ssee_pkg::PAGE_BYTES; i++)
                begin
                    if (st.mask[i])
                    begin
                        next_st.mem[{st.page, ssee_pkg::PAGE_SEL_W'(i)}] = st.lat[i];
                    end
                end
                next_st.mask = 4'h0;
                next_st.prog = 1'b0;
                next_st.pcnt = '0;
            end
        end

        // Standby needs no frame, no generator and no write waiting.
        next_st.standby = ~st.act_s & ~st.vpp & ~st.prog
            & (st.mask == 4'h0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; a low clock enable freezes the core.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st <= '0;
            st.phase <= ssee_pkg::PH_OPC;
            st.standby <= 1'b1;
            st.mem <= {ssee_pkg::MEM_BYTES{ssee_pkg::ERASED}};
        end
        else if (CE)
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from state flip-flops.
    assign SERIAL_OUT_LINE = st.so;
    assign SERIAL_OUT_OE = st.so_oe;
    assign VPP_GEN_ON = st.vpp;
    assign VPP_ARRAY_GATE = st.prog;
    assign PROGRAMMING = st.prog;
    assign STANDBY = st.standby;
endmodule

//--- dv/ssee_spi_eeprom_properties.sv
// Checker of the serial EEPROM slave, bound to its top module.
// Assumes CE held high and a serial clock far slower than CLK.
`timescale 1ns/100ps
module ssee_spi_eeprom_properties
#(
    parameter int PROG_ONE_CYC = 20,
    parameter int PROG_PAGE_CYC = 40
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic DEVICE_SELECT_N,
    input wire logic SERIAL_IN_LINE,
    input wire logic MODE_SPI,
    input wire logic SERIAL_OUT_LINE,
    input wire logic SERIAL_OUT_OE,
    input wire logic VPP_GEN_ON,
    input wire logic VPP_ARRAY_GATE,
    input wire logic PROGRAMMING,
    input wire logic STANDBY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    int run_len;
    // Counts the cycles of the current programming run.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            run_len <= 0;
        else
            run_len <= PROGRAMMING ? run_len + 1 : 0;
    end
    a_desel_quiet: assert property (DEVICE_SELECT_N [*6] |-> !SERIAL_OUT_OE)
        else $error("Output driven while deselected.");
    a_sel_drive: assert property
        ($fell(DEVICE_SELECT_N) && MODE_SPI |-> ##[2:6] SERIAL_OUT_OE)
        else $error("Output not enabled at frame start.");
    a_mode_quiet: assert property (!MODE_SPI [*6] |-> !SERIAL_OUT_OE)
        else $error("Output driven with mode input low.");
    a_out_on_fall: assert property (SERIAL_OUT_OE && $past(SERIAL_OUT_OE)
        && $changed(SERIAL_OUT_LINE) |-> !SERIAL_CLOCK_IN)
        else $error("Output changed while serial clock high.");
    a_gen_awake: assert property (VPP_GEN_ON && $past(VPP_GEN_ON) |-> !STANDBY)
        else $error("Standby with generator on.");
    a_sel_awake: assert property ((!DEVICE_SELECT_N && MODE_SPI) [*6] |-> !STANDBY)
        else $error("Standby while selected.");
    a_gate_prog: assert property (VPP_ARRAY_GATE == (PROGRAMMING && VPP_GEN_ON))
        else $error("Array gate differs from programming run.");
    a_prog_start: assert property
        ($rose(PROGRAMMING) |-> $past(DEVICE_SELECT_N) && VPP_GEN_ON)
        else $error("Programming started without enable or deselect.");
    a_prog_hold: assert property (!DEVICE_SELECT_N [*6] |-> !PROGRAMMING)
        else $error("Programming while selected.");
    a_run_len: assert property ($fell(PROGRAMMING) && DEVICE_SELECT_N && VPP_GEN_ON
        |-> run_len inside {PROG_ONE_CYC, PROG_PAGE_CYC})
        else $error("Programming run of wrong length.");
endmodule
bind ssee_spi_eeprom ssee_spi_eeprom_properties #(.PROG_ONE_CYC(PROG_ONE_CYC),
    .PROG_PAGE_CYC(PROG_PAGE_CYC)) u_props (.CLK(CLK), .RST(RST), .CE(CE),
    .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .DEVICE_SELECT_N(DEVICE_SELECT_N),
    .SERIAL_IN_LINE(SERIAL_IN_LINE), .MODE_SPI(MODE_SPI), .SERIAL_OUT_LINE(SERIAL_OUT_LINE),
    .SERIAL_OUT_OE(SERIAL_OUT_OE), .VPP_GEN_ON(VPP_GEN_ON), .VPP_ARRAY_GATE(VPP_ARRAY_GATE),
    .PROGRAMMING(PROGRAMMING), .STANDBY(STANDBY));

//--- dv/ssee_master.sv
// Serial bus master model driving clock, select and data into the slave.
// Assumes the half period is well above the slave's synchroniser delay.
`timescale 1ns/100ps
module ssee_master
#(
    parameter int HALF = 300
)
(
    output logic sck,
    output logic ss_n,
    output logic si,
    input wire logic so,
    input wire logic oe
);
    logic cpol = 1'b0;
    // Idle levels before the first frame.
    initial
    begin
        sck = 1'b0;
        ss_n = 1'b1;
        si = 1'b0;
    end
    // Selects the device with the clock at its idle level.
    task automatic start(input logic pol);
        cpol = pol;
        sck = pol;
        #(HALF);
        ss_n = 1'b0;
        #(HALF);
    endtask
    // Swaps one byte; bits read while the output is off come back unknown.
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            si = tx[i];
            #(HALF);
            sck = 1'b1;
            rx[i] = (oe === 1'b1) ? so : 1'bx;
            #(HALF);
        end
    endtask
    // Returns the clock to idle, deselects and drives the inverse of the old data value.
    task automatic stop();
        sck = cpol;
        #(HALF);
        ss_n = 1'b1;
        si = ~si;
        #(2 * HALF);
    endtask
endmodule

//--- dv/tb.sv
// Self-checking bench of the serial EEPROM slave with a master model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/100ps
module tb;
    localparam int ONE = 20;
    localparam int PAGE = 40;
    logic clk, rst, ce, mode;
    logic sck, ss_n, si, so, oe, gen, gate, prog, stby;
    logic [39:0] got;
    int err_count = 0;
    int checks_done = 0;
    ssee_spi_eeprom #(.PROG_ONE_CYC(ONE), .PROG_PAGE_CYC(PAGE)) dut (.CLK(clk), .RST(rst),
        .CE(ce), .SERIAL_CLOCK_IN(sck), .DEVICE_SELECT_N(ss_n), .SERIAL_IN_LINE(si),
        .MODE_SPI(mode), .SERIAL_OUT_LINE(so), .SERIAL_OUT_OE(oe), .VPP_GEN_ON(gen),
        .VPP_ARRAY_GATE(gate), .PROGRAMMING(prog), .STANDBY(stby));
    ssee_master master (.sck(sck), .ss_n(ss_n), .si(si), .so(so), .oe(oe));
    // System clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compares one value with its expectation and counts a mismatch.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One frame of n bytes; received bytes land in got, first byte on top.
    task automatic run(input logic pol, input logic [39:0] tx, input int n);
        got = '1;
        master.start(pol);
        for (int i = 0; i < n; i++)
            master.xbyte(tx[39 - 8 * i -: 8], got[39 - 8 * i -: 8]);
        master.stop();
        repeat (6) @(posedge clk);
        #1;
        check({7'h00, oe}, 8'h00);
    endtask
    task automatic t_reset_mode();
        check({5'h00, stby, gen, prog}, 8'h04);
        mode = 1'b0;
        run(0, 40'ha710000000, 3);
        check(got[39:32], 8'hxx);
        mode = 1'b1;
    endtask
    task automatic t_read_inc();
        run(0, 40'ha710000000, 4);
        check(got[39:32], 8'h00);
        check(got[31:24], 8'hff);
        check(got[23:16], 8'hff);
        run(0, 40'ha740000000, 2);
        check(got[39:32], 8'h12);
        check({7'h00, stby}, 8'h01);
    endtask
    task automatic t_page_write();
        run(0, 40'ha600000000, 1);
        check(got[39:32], 8'h40);
        check({6'h00, gen, stby}, 8'h02);
        run(0, 40'ha2225aa5c3, 5);
        check(got[23:16], 8'h22);
        check(got[15:0] == 16'hffff, 8'h01);
        check({6'h00, prog, gate}, 8'h03);
        for (int i = 0; i < 200 && prog !== 1'b0; i++)
        begin
            @(posedge clk);
            #1;
        end
        check({7'h00, prog}, 8'h00);
        run(0, 40'ha722000000, 5);
        check(got[39:32], 8'h25);
        check(got[23:0] == 24'h5aa5ff, 8'h01);
    endtask
    task automatic t_disable();
        run(0, 40'ha400000000, 1);
        check({6'h00, gen, stby}, 8'h01);
        run(0, 40'ha230770000, 3);
        repeat (10) @(posedge clk);
        #1;
        check({6'h00, prog, gate}, 8'h00);
        run(0, 40'ha730000000, 3);
        check(got[23:16], 8'hff);
        run(0, 40'ha600000000, 1);
        check({6'h00, prog, gate}, 8'h00);
        run(0, 40'ha400000000, 1);
        check({6'h00, gen, stby}, 8'h01);
    endtask
    task automatic t_invalid_pol();
        run(0, 40'h55a7300000, 4);
        check(got[39:32], 8'h31);
        check(got[31:24], 8'hxx);
        check(got[15:8], 8'hxx);
        run(1, 40'ha722000000, 3);
        check(got[39:32], 8'h31);
        check(got[23:16], 8'h5a);
    endtask
    // Reset, then the scenarios in order.
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        mode = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reset_mode();
        t_read_inc();
        t_page_write();
        t_disable();
        t_invalid_pol();
        summarize();
    end
    // Cuts a hang short well past the expected run time.
    initial
    begin
        #1500000;
        err_count++;
        summarize();
    end
endmodule
